// ==== inc/fplc_defines.svh ====
// offsets, field positions, reset values and timing counts of the lock block
`ifndef FPLC_DEFINES_SVH
`define FPLC_DEFINES_SVH

// ----------------------------------------------------------------------
// fuse register offsets
// ----------------------------------------------------------------------
`define FPLC_OFF_STARTUP 4'h6
`define FPLC_OFF_APP_END 4'h7
`define FPLC_OFF_BOOT_END 4'h8
`define FPLC_OFF_LOCK_KEY 4'ha

// ----------------------------------------------------------------------
// field positions and values
// ----------------------------------------------------------------------
`define FPLC_SUT_MSB 2
`define FPLC_SUT_LSB 0
`define FPLC_LOCK_OPEN_KEY 8'hc5
`define FPLC_LIMIT_NONE 8'h00
`define FPLC_BLOCK_BYTES_LOG2 8

// ----------------------------------------------------------------------
// reset values of the sampled copies
// ----------------------------------------------------------------------
`define FPLC_RST_BYTE 8'h00
`define FPLC_RST_LOCKED 1'b1

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define FPLC_CLK_PERIOD_NS 25
`define FPLC_ONE_MS_IN_NS 1000000

`endif

// ==== inc/fplc_pkg.sv ====
// types shared by the fuse partition lock block
package fplc_pkg;

  // ----------------------------------------------------------------------
  // control sequence states, one-hot
  // ----------------------------------------------------------------------
  typedef enum logic [2:0]
  {
    FPLC_ST_SAMPLE = 3'b001,
    FPLC_ST_HOLD = 3'b010,
    FPLC_ST_RUN = 3'b100
  } fplc_state_t;

  // ----------------------------------------------------------------------
  // flash section of an address
  // ----------------------------------------------------------------------
  typedef enum logic [1:0]
  {
    FPLC_SEC_BOOT = 2'h0,
    FPLC_SEC_APPLICATION_CODE_SECTION = 2'h1,
    FPLC_SEC_APPLICATION_DATA_SECTION = 2'h2
  } fplc_section_t;

  // ----------------------------------------------------------------------
  // memory space targeted by an access
  // ----------------------------------------------------------------------
  typedef enum logic [3:0]
  {
    FPLC_SP_SRAM = 4'h0,
    FPLC_SP_REGS = 4'h1,
    FPLC_SP_FLASH = 4'h2,
    FPLC_SP_EEPROM = 4'h3,
    FPLC_SP_USER_CONFIG_ROW = 4'h4,
    FPLC_SP_SIGNATURE_AREA = 4'h5,
    FPLC_SP_FUSE = 4'h6,
    FPLC_SP_DBG_CS = 4'h7,
    FPLC_SP_ASYNC_IF = 4'h8
  } fplc_space_t;

endpackage : fplc_pkg

// ==== src/fplc_access_gate.sv ====
// access permission of one requester (cpu or debug port) per memory space
`timescale 1ns/1ps

module fplc_access_gate #(
  parameter bit IS_DEBUG = 1'b0
) (
  input wire logic locked_i,
  input wire logic req_i,
  input wire logic we_i,
  input wire fplc_pkg::fplc_space_t space_i,
  output logic allow_o
);

  // ----------------------------------------------------------------------
  // space decode
  // ----------------------------------------------------------------------
  wire logic sp_ro_area; // signature area or fuses
  wire logic sp_sig; // signature area only
  wire logic sp_dbg_own; // debug control space or async interface
  wire logic sp_user; // user config row
  wire logic cpu_ok; // cpu permission
  wire logic dbg_open_ok; // debug permission while open
  wire logic dbg_lock_ok; // debug permission while locked

  assign sp_sig = (space_i == fplc_pkg::FPLC_SP_SIGNATURE_AREA);
  assign sp_ro_area = sp_sig || (space_i == fplc_pkg::FPLC_SP_FUSE);
  assign sp_dbg_own = (space_i == fplc_pkg::FPLC_SP_DBG_CS) ||
                      (space_i == fplc_pkg::FPLC_SP_ASYNC_IF);
  assign sp_user = (space_i == fplc_pkg::FPLC_SP_USER_CONFIG_ROW);

  // cpu view ignores the lock state entirely
  assign cpu_ok = !(we_i && sp_ro_area) && !sp_dbg_own; // [RULE14]

  // open device: everything but signature-area writes
  assign dbg_open_ok = !(we_i && sp_sig); // [RULE13]

  // locked: own space, async interface and blind user row writes only
  assign dbg_lock_ok = sp_dbg_own || (we_i && sp_user); // [RULE9] [RULE11]

  // denied debug access to all memories when locked, except user row writes
  assign allow_o = req_i && (IS_DEBUG ?
                   (locked_i ? dbg_lock_ok : dbg_open_ok) : cpu_ok); // [RULE10]

endmodule : fplc_access_gate

// ==== src/fplc_lock_ctrl.sv ====
// fuse sampling, start-up delay, flash sections and debug lock gating
//
// What this block does
// RULE1: start-up delay from three-bit fuse, 0..64 ms
// RULE2: application code end in 256-byte blocks
// RULE3: flash above code end is application data
// RULE4: code end zero: code runs to flash top
// RULE5: boot end fuse counts 256-byte blocks
// RULE6: boot end zero makes whole flash boot
// RULE7: only key c5 leaves device open
// RULE8: programmer locks by writing any other key
// RULE9: locked debug reaches own space, async interface
// RULE10: locked debug denied all memories; cpu unchanged
// RULE11: locked debug may write, not read, user row
// RULE12: denied debug reads return non-memory data
// RULE13: open debug full access, signature area read-only
// RULE14: cpu reads only signature area and fuses
// RULE15: only full device erase unlocks, resets everything
// RULE16: locked erase also clears eeprom despite preserve
// RULE17: fuses sampled at reset, held until reset
`timescale 1ns/1ps
`include "fplc_defines.svh"

module fplc_lock_ctrl #(
  // cycles per millisecond, shortened in simulation
  parameter int unsigned CYC_PER_MS =
    `FPLC_ONE_MS_IN_NS / `FPLC_CLK_PERIOD_NS
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  // raw fuse values from fuse storage
  input wire logic [7:0] fuse_startup_i,
  input wire logic [7:0] fuse_app_end_i,
  input wire logic [7:0] fuse_boot_end_i,
  input wire logic [7:0] fuse_lock_key_i,
  input wire logic fuse_eeprom_preserve_i,
  // cpu start control
  output logic cpu_run_o,
  // fuse register read port
  input wire logic fuse_rd_i,
  input wire logic [3:0] fuse_addr_i,
  output logic [7:0] fuse_rdata_o,
  // flash section lookup
  input wire logic [15:0] flash_addr_i,
  output logic [1:0] flash_section_o,
  // cpu access gate
  input wire logic cpu_req_i,
  input wire logic cpu_we_i,
  input wire fplc_pkg::fplc_space_t cpu_space_i,
  output logic cpu_grant_o,
  // debug port access gate
  input wire logic dbg_req_i,
  input wire logic dbg_we_i,
  input wire fplc_pkg::fplc_space_t dbg_space_i,
  input wire logic [7:0] dbg_mem_rdata_i,
  output logic dbg_grant_o,
  output logic dbg_rvalid_o,
  output logic [7:0] dbg_rdata_o,
  // full device erase
  input wire logic full_device_erase_i,
  output logic erase_start_o,
  output logic erase_eeprom_o,
  output logic locked_o
);
  // all checks below run on the system clock, off during reset
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  // ----------------------------------------------------------------------
  // sampled fuse copies and state
  // ----------------------------------------------------------------------
  fplc_pkg::fplc_state_t state_r; // sequence state
  fplc_pkg::fplc_state_t state_nxt;
  logic [2:0] startup_delay_sel_r; // sampled delay code
  logic [7:0] app_code_limit_r; // sampled code end
  logic [7:0] boot_limit_r; // sampled boot end
  logic [7:0] lock_key_r; // sampled key
  logic eeprom_preserve_on_erase_r; // sampled preserve bit
  logic locked_r; // decoded lock state
  logic [31:0] delay_cnt_r; // start-up delay counter
  logic [31:0] delay_cnt_nxt;
  logic [7:0] fuse_rdata_r; // fuse read data
  logic [7:0] dbg_rdata_r; // debug read data
  logic dbg_rvalid_r; // debug read answer
  logic erase_start_r; // erase launch pulse
  logic erase_eeprom_r; // eeprom erase select

  // ----------------------------------------------------------------------
  // delay target from the code: 0, then 1 ms doubling up to 64 ms
  // ----------------------------------------------------------------------
  function automatic logic [31:0] delay_cycles(input logic [2:0] code);
    logic [31:0] res;
    res = 32'h0;
    if (code != 3'h0)
    begin
      res = 32'(CYC_PER_MS) << (code - 3'h1);
    end
    return res;
  endfunction : delay_cycles

  wire logic [31:0] delay_target; // cycles to wait
  wire logic delay_done; // delay expired
  wire logic lock_open; // key matches

  assign delay_target = delay_cycles(startup_delay_sel_r); // [RULE1]
  assign delay_done = (delay_cnt_r >= delay_target);
  // any key but the open one locks the device
  assign lock_open = (fuse_lock_key_i == `FPLC_LOCK_OPEN_KEY); // [RULE7] [RULE8]

  // ----------------------------------------------------------------------
  // sequence: sample fuses, hold cpu for the delay, run
  // ----------------------------------------------------------------------
  always_comb
  begin
    state_nxt = state_r;
    delay_cnt_nxt = delay_cnt_r;
    case (state_r)
      fplc_pkg::FPLC_ST_SAMPLE:
      begin
        // one cycle after release the fuses are captured
        state_nxt = fplc_pkg::FPLC_ST_HOLD;
        delay_cnt_nxt = 32'h0;
      end
      fplc_pkg::FPLC_ST_HOLD:
      begin
        // count until the selected start-up time elapses
        if (delay_done)
        begin
          state_nxt = fplc_pkg::FPLC_ST_RUN; // [RULE1]
        end
        else
        begin
          delay_cnt_nxt = delay_cnt_r + 32'h1;
        end
      end
      fplc_pkg::FPLC_ST_RUN:
      begin
        // stays here until the next reset
        state_nxt = fplc_pkg::FPLC_ST_RUN;
      end
      default:
      begin
        state_nxt = fplc_pkg::FPLC_ST_SAMPLE;
      end
    endcase
  end

  // state and counter flops
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state_r <= fplc_pkg::FPLC_ST_SAMPLE;
      delay_cnt_r <= 32'h0;
    end
    else
    begin
      state_r <= state_nxt;
      delay_cnt_r <= delay_cnt_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // fuse capture, only in the sample state, then frozen
  // ----------------------------------------------------------------------
  // reset loads constants; the real fuse levels are taken after release
  wire logic capture; // sample strobe
  assign capture = (state_r == fplc_pkg::FPLC_ST_SAMPLE);

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      startup_delay_sel_r <= 3'h0;
      app_code_limit_r <= `FPLC_RST_BYTE;
      boot_limit_r <= `FPLC_RST_BYTE;
      lock_key_r <= `FPLC_RST_BYTE;
      eeprom_preserve_on_erase_r <= 1'b0;
      locked_r <= `FPLC_RST_LOCKED; // safe until the key is known
    end
    else if (capture)
    begin
      startup_delay_sel_r <= fuse_startup_i[`FPLC_SUT_MSB:`FPLC_SUT_LSB];
      app_code_limit_r <= fuse_app_end_i; // [RULE17]
      boot_limit_r <= fuse_boot_end_i;
      lock_key_r <= fuse_lock_key_i;
      eeprom_preserve_on_erase_r <= fuse_eeprom_preserve_i;
      locked_r <= !lock_open; // [RULE17]
    end
  end

  // ----------------------------------------------------------------------
  // flash section classification
  // ----------------------------------------------------------------------
  wire logic [7:0] addr_block; // 256-byte block number
  wire logic below_boot; // inside boot blocks
  wire logic below_code; // inside code blocks
  wire logic boot_all; // boot limit zero
  wire logic code_to_top; // code limit zero

  assign addr_block = flash_addr_i[15:`FPLC_BLOCK_BYTES_LOG2]; // [RULE2]
  assign boot_all = (boot_limit_r == `FPLC_LIMIT_NONE);
  assign code_to_top = (app_code_limit_r == `FPLC_LIMIT_NONE);
  assign below_boot = (addr_block < boot_limit_r); // [RULE5]
  assign below_code = (addr_block < app_code_limit_r); // [RULE2]

  // boot-end zero overrides the code end
  assign flash_section_o =
    (boot_all || below_boot) ? fplc_pkg::FPLC_SEC_BOOT : // [RULE6]
    (code_to_top || below_code) ? fplc_pkg::FPLC_SEC_APPLICATION_CODE_SECTION : // [RULE4]
    fplc_pkg::FPLC_SEC_APPLICATION_DATA_SECTION; // [RULE3]

  // ----------------------------------------------------------------------
  // access gates
  // ----------------------------------------------------------------------
  fplc_access_gate #(
    .IS_DEBUG(1'b0)
  ) u_cpu_gate (
    .locked_i(locked_r),
    .req_i(cpu_req_i),
    .we_i(cpu_we_i),
    .space_i(cpu_space_i),
    .allow_o(cpu_grant_o)
  );

  fplc_access_gate #(
    .IS_DEBUG(1'b1)
  ) u_dbg_gate (
    .locked_i(locked_r),
    .req_i(dbg_req_i),
    .we_i(dbg_we_i),
    .space_i(dbg_space_i),
    .allow_o(dbg_grant_o)
  );

  // ----------------------------------------------------------------------
  // debug read answer: always answers, memory data only when granted
  // ----------------------------------------------------------------------
  wire logic dbg_rd; // debug read request
  wire logic [7:0] dbg_rd_val; // data to return
  assign dbg_rd = dbg_req_i && !dbg_we_i;
  // no error flag: a denied read just reads as zero
  assign dbg_rd_val = dbg_grant_o ? dbg_mem_rdata_i : 8'h00; // [RULE12]

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      dbg_rvalid_r <= 1'b0;
      dbg_rdata_r <= 8'h00;
    end
    else
    begin
      dbg_rvalid_r <= dbg_rd;
      dbg_rdata_r <= dbg_rd ? dbg_rd_val : 8'h00; // [RULE12]
    end
  end

  // ----------------------------------------------------------------------
  // fuse register read port, sampled copies, reserved bits zero
  // ----------------------------------------------------------------------
  wire logic [7:0] fuse_sel; // decoded read value
  assign fuse_sel =
    (fuse_addr_i == `FPLC_OFF_STARTUP) ? {5'h00, startup_delay_sel_r} :
    (fuse_addr_i == `FPLC_OFF_APP_END) ? app_code_limit_r :
    (fuse_addr_i == `FPLC_OFF_BOOT_END) ? boot_limit_r :
    (fuse_addr_i == `FPLC_OFF_LOCK_KEY) ? lock_key_r : 8'h00;

  // read-only: there is no write path to these copies
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      fuse_rdata_r <= 8'h00;
    end
    else if (fuse_rd_i)
    begin
      fuse_rdata_r <= fuse_sel; // [RULE14]
    end
  end

  // ----------------------------------------------------------------------
  // full device erase: always accepted, even when locked
  // ----------------------------------------------------------------------
  // unlock happens at the next reset when the erased fuses read open
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      erase_start_r <= 1'b0;
      erase_eeprom_r <= 1'b0;
    end
    else
    begin
      erase_start_r <= full_device_erase_i; // [RULE15]
      if (full_device_erase_i)
      begin
        erase_eeprom_r <= locked_r || !eeprom_preserve_on_erase_r; // [RULE16]
      end
    end
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  assign cpu_run_o = (state_r == fplc_pkg::FPLC_ST_RUN);
  assign fuse_rdata_o = fuse_rdata_r;
  assign dbg_rvalid_o = dbg_rvalid_r;
  assign dbg_rdata_o = dbg_rdata_r;
  assign erase_start_o = erase_start_r;
  assign erase_eeprom_o = erase_eeprom_r;
  assign locked_o = locked_r;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  chk_lock_decode: assert property (capture |=> // [RULE7]
    locked_r == ($past(fuse_lock_key_i) != 8'hc5))
    else $error("lock state does not follow the key");
  chk_lock_stable: assert property (!capture |=> // [RULE17]
    $stable(locked_r) && $stable(boot_limit_r) && $stable(app_code_limit_r))
    else $error("sampled fuse changed after capture");
  chk_run_delay: assert property ($rose(cpu_run_o) |-> // [RULE1]
    delay_cnt_r == delay_target)
    else $error("cpu released before start-up delay");
  chk_zero_delay: assert property (capture && // [RULE1]
    fuse_startup_i[2:0] == 3'h0 |-> ##2 cpu_run_o)
    else $error("zero delay did not run at once");
  chk_boot_all: assert property (boot_limit_r == 8'h00 |-> // [RULE6]
    flash_section_o == 2'h0)
    else $error("boot end zero must make all flash boot");
  chk_data_sec: assert property (flash_section_o == 2'h2 |-> // [RULE3]
    addr_block >= app_code_limit_r && app_code_limit_r != 8'h00 &&
    boot_limit_r != 8'h00)
    else $error("data section below code end");
  chk_code_top: assert property (app_code_limit_r == 8'h00 && // [RULE4]
    boot_limit_r != 8'h00 && addr_block >= boot_limit_r |->
    flash_section_o == 2'h1)
    else $error("code end zero must run to flash top");
  chk_lock_deny: assert property (locked_r && dbg_req_i && // [RULE10]
    dbg_space_i < fplc_pkg::FPLC_SP_DBG_CS &&
    dbg_space_i != fplc_pkg::FPLC_SP_USER_CONFIG_ROW |-> !dbg_grant_o)
    else $error("locked debug reached a memory");
  chk_rd_masked: assert property (dbg_rd && !dbg_grant_o |=> // [RULE12]
    dbg_rvalid_o && dbg_rdata_o == 8'h00)
    else $error("denied read leaked data");
  chk_user_write: assert property (locked_r && dbg_req_i && // [RULE11]
    dbg_space_i == fplc_pkg::FPLC_SP_USER_CONFIG_ROW |-> dbg_grant_o == dbg_we_i)
    else $error("locked user row access wrong");
  chk_cpu_ro: assert property (cpu_req_i && cpu_we_i && // [RULE14]
    cpu_space_i == fplc_pkg::FPLC_SP_FUSE |-> !cpu_grant_o)
    else $error("cpu wrote fuses");
  chk_sig_ro: assert property (!locked_r && dbg_req_i && // [RULE13]
    dbg_space_i == fplc_pkg::FPLC_SP_SIGNATURE_AREA |-> dbg_grant_o == !dbg_we_i)
    else $error("open signature area access wrong");
  chk_erase_ee: assert property (locked_r && // [RULE16]
    full_device_erase_i |=> erase_start_o && erase_eeprom_o)
    else $error("locked erase kept eeprom");

  cov_locked_erase: cover property (locked_r && full_device_erase_i);
  cov_denied_read: cover property (dbg_rd && locked_r);
  cov_run: cover property ($rose(cpu_run_o));
  cov_data_sec: cover property (flash_section_o == 2'h2);

endmodule : fplc_lock_ctrl

// ==== verif/fplc_dbg_model.sv ====
// debugger model that issues debug port accesses, one per clock
`timescale 1ns/1ps

module fplc_dbg_model (
  input wire logic clk_i,
  input wire logic grant_i,
  output logic req_o,
  output logic we_o,
  output fplc_pkg::fplc_space_t space_o
);
  // idle at time zero
  initial
  begin
    req_o = 1'b0;
    we_o = 1'b0;
    space_o = fplc_pkg::FPLC_SP_SRAM;
  end

  // hold one request across a rising edge, report the grant seen with it
  task automatic access(input logic we, input fplc_pkg::fplc_space_t sp,
                        output logic g);
    req_o = 1'b1;
    we_o = we;
    space_o = sp;
    #1 g = grant_i;
    @(negedge clk_i);
  endtask : access

  // release: qualifiers flip so a stale value is never mistaken for a hold
  task automatic idle();
    req_o = 1'b0;
    we_o = ~we_o;
    space_o = fplc_pkg::fplc_space_t'(~space_o);
    @(negedge clk_i);
  endtask : idle
endmodule : fplc_dbg_model

// ==== verif/test_fuse_partition_lock_control.sv ====
// self-checking bench for the fuse partition lock block
`timescale 1ns/1ps

module test_fuse_partition_lock_control;
  // ----------------------------------------------------------------------
  // stimulus and observed signals
  // ----------------------------------------------------------------------
  localparam int unsigned CYC = 4; // cycles per ms, short for simulation
  logic clk_i = 1'b0, rst_n_i = 1'b0, fpres = 1'b1, frd = 1'b0;
  logic erase = 1'b0, cpu_req = 1'b0, cpu_we = 1'b0;
  logic [7:0] fsut = 8'h00, fapp = 8'h00, fboot = 8'h00, fkey = 8'hc5;
  logic [7:0] mem = 8'h00;
  logic [3:0] faddr = 4'h0;
  logic [15:0] faddr16 = 16'h0000;
  fplc_pkg::fplc_space_t cpu_sp = fplc_pkg::FPLC_SP_SRAM;
  fplc_pkg::fplc_space_t dbg_sp;
  logic dbg_req, dbg_we, cpu_run_o, cpu_grant_o, dbg_grant_o, dbg_rvalid_o;
  logic erase_start_o, erase_eeprom_o, locked_o;
  logic [7:0] fuse_rdata_o, dbg_rdata_o;
  logic [1:0] flash_section_o;
  logic [7:0] exp_q[$]; // expected debug read data, oldest first
  int failures = 0, comparisons = 0, n;
  integer seed = 32'h70d3;

  // free-running 40 MHz clock
  initial
  begin
    forever #12.5 clk_i = ~clk_i;
  end

  fplc_lock_ctrl #(.CYC_PER_MS(CYC)) dut (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .fuse_startup_i(fsut), .fuse_app_end_i(fapp), .fuse_boot_end_i(fboot),
    .fuse_lock_key_i(fkey), .fuse_eeprom_preserve_i(fpres),
    .cpu_run_o(cpu_run_o), .fuse_rd_i(frd), .fuse_addr_i(faddr),
    .fuse_rdata_o(fuse_rdata_o), .flash_addr_i(faddr16),
    .flash_section_o(flash_section_o), .cpu_req_i(cpu_req),
    .cpu_we_i(cpu_we), .cpu_space_i(cpu_sp), .cpu_grant_o(cpu_grant_o),
    .dbg_req_i(dbg_req), .dbg_we_i(dbg_we), .dbg_space_i(dbg_sp),
    .dbg_mem_rdata_i(mem), .dbg_grant_o(dbg_grant_o),
    .dbg_rvalid_o(dbg_rvalid_o), .dbg_rdata_o(dbg_rdata_o),
    .full_device_erase_i(erase), .erase_start_o(erase_start_o),
    .erase_eeprom_o(erase_eeprom_o), .locked_o(locked_o));

  fplc_dbg_model dbg (.clk_i(clk_i), .grant_i(dbg_grant_o),
    .req_o(dbg_req), .we_o(dbg_we), .space_o(dbg_sp));

  // ----------------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      failures++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // reset with given fuses, count edges until the cpu may run
  task automatic do_reset(input logic [7:0] s, a, b, k);
    fsut = s;
    fapp = a;
    fboot = b;
    fkey = k;
    rst_n_i = 1'b0;
    repeat (10) @(negedge clk_i);
    rst_n_i = 1'b1;
    n = 0;
    while (cpu_run_o !== 1'b1 && n < 400)
    begin
      @(posedge clk_i);
      #1 n++;
    end
    @(negedge clk_i);
  endtask : do_reset

  // fuse read; strobe is left high so back-to-back reads need no gap
  task automatic rd_fuse(input logic [3:0] a, input logic [7:0] e);
    frd = 1'b1;
    faddr = a;
    @(negedge clk_i);
    check(fuse_rdata_o, e);
  endtask : rd_fuse

  task automatic sec(input logic [15:0] a, input logic [1:0] e);
    faddr16 = a;
    #1 check({6'h00, flash_section_o}, {6'h00, e});
    @(negedge clk_i);
  endtask : sec

  // every space, read then write, back to back; reads queue their data
  task automatic dbg_sweep(input logic lk);
    logic g;
    logic e;
    for (int s = 0; s < 9; s++)
      for (int w = 0; w < 2; w++)
      begin
        mem = $random(seed);
        if (lk) e = (s >= 7) || (s == 4 && w == 1);
        else e = !(s == 5 && w == 1);
        if (w == 0) exp_q.push_back(e ? mem : 8'h00);
        dbg.access(w[0], fplc_pkg::fplc_space_t'(s), g);
        check({7'h00, g}, {7'h00, e});
      end
    dbg.idle();
    check(exp_q.size(), 8'h00);
  endtask : dbg_sweep

  // cpu rights do not depend on the lock state
  task automatic cpu_sweep();
    for (int s = 0; s < 9; s++)
      for (int w = 0; w < 2; w++)
      begin
        cpu_req = 1'b1;
        cpu_we = w[0];
        cpu_sp = fplc_pkg::fplc_space_t'(s);
        #1 check(cpu_grant_o, (s < 5 || (s < 7 && w == 0)));
        @(negedge clk_i);
      end
    cpu_req = 1'b0;
  endtask : cpu_sweep

  // monitor: each read answer takes the oldest note
  always @(negedge clk_i)
    if (dbg_rvalid_o === 1'b1)
    begin
      if (exp_q.size() == 0) check(8'hxx, 8'h00);
      else check(dbg_rdata_o, exp_q.pop_front());
    end

  task automatic tally_and_finish();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : tally_and_finish

  // watchdog at 20000 cycles, far beyond the expected run of under a thousand cycles
  initial
  begin
    #(20000 * 25);
    failures++;
    tally_and_finish();
  end

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial
  begin
    logic [7:0] k;
    // every delay code; upper fuse bits set to prove they are ignored
    for (int c = 0; c < 8; c++)
    begin
      do_reset(8'hf8 | c[7:0], 8'h10, 8'h04, 8'hc5);
      check(n, 2 + ((c == 0) ? 0 : (1 << (c - 1))) * CYC);
      rd_fuse(4'h6, c[7:0]);
      frd = 1'b0;
    end
    $display("test start-up delay done");
    rd_fuse(4'h7, 8'h10);
    rd_fuse(4'h8, 8'h04);
    rd_fuse(4'ha, 8'hc5);
    rd_fuse(4'h9, 8'h00);
    frd = 1'b0;
    check(locked_o, 8'h00);
    sec(16'h03ff, 2'h0);
    sec(16'h0400, 2'h1);
    sec(16'h0fff, 2'h1);
    sec(16'h1000, 2'h2);
    sec(16'hffff, 2'h2);
    dbg_sweep(1'b0);
    cpu_sweep();
    $display("test open device done");
    // programmer locks by any key but the open one
    k = $random(seed);
    if (k == 8'hc5) k = 8'h3a;
    fpres = 1'b1;
    do_reset(8'h00, 8'h10, 8'h00, k);
    check(locked_o, 8'h01);
    fkey = 8'hc5;
    fboot = 8'h20;
    sec(16'h1000, 2'h0);
    sec(16'hffff, 2'h0);
    dbg_sweep(1'b1);
    cpu_sweep();
    check(locked_o, 8'h01);
    erase = 1'b1;
    @(negedge clk_i);
    erase = 1'b0;
    check(erase_start_o, 8'h01);
    check(erase_eeprom_o, 8'h01);
    @(negedge clk_i);
    check(erase_start_o, 8'h00);
    check({erase_eeprom_o, locked_o}, 8'h03);
    $display("test locked device done");
    // erased key comes back open after reset; code end zero case
    do_reset(8'h00, 8'h00, 8'h02, 8'hc5);
    check(locked_o, 8'h00);
    sec(16'h01ff, 2'h0);
    sec(16'h0200, 2'h1);
    sec(16'hffff, 2'h1);
    // open erase honours the preserve bit, which is still set
    erase = 1'b1;
    @(negedge clk_i);
    erase = 1'b0;
    check(erase_start_o, 8'h01);
    check(erase_eeprom_o, 8'h00);
    $display("test unlock and code end zero done");
    tally_and_finish();
  end
endmodule : test_fuse_partition_lock_control
